// ==== host_port_pkg.sv ====
// Purpose: shared constants and carriers for the slave host data buffer port
// Assumes: one 40 MHz clock, synchronous active-high reset
// Notes:   status byte layout and handshake pin positions live here
package host_port_pkg;

	localparam int DATA_W = 8;

	// Status byte field positions
	localparam int ST_OUT_FULL_BIT = 0;
	localparam int ST_IN_FULL_BIT = 1;
	localparam int ST_CMD_BIT = 3;
	localparam int ST_UPPER_LO = 4;
	localparam logic [7:0] ST_RESET = 8'h00;

	// Handshake pin group positions, ascending
	localparam int HS_OUT_FULL = 0;
	localparam int HS_IN_FULL = 1;
	localparam int HS_DMA_REQ = 2;
	localparam int HS_DMA_ACK = 3;

	// Strobe to request-cleared bound and its cycle count (round down)
	localparam int CLK_PERIOD_NS = 25;
	localparam int DMA_REQ_CLEAR_NS = 200;
	localparam int DMA_REQ_CLEAR_CYC = DMA_REQ_CLEAR_NS / CLK_PERIOD_NS;

	// Host-side pins, all synchronous to clk_i
	typedef struct packed {
		logic       sel_n;
		logic       rd_n;
		logic       wr_n;
		logic       dc;
		logic [7:0] data;
	} host_pins_t;

	// Internal program side requests
	typedef struct packed {
		logic       fetch;
		logic       post;
		logic       upper_load;
		logic [7:0] acc;
	} prog_req_t;

endpackage : host_port_pkg

// ==== strobe_edge.sv ====
// Purpose: turns a qualified active-high strobe level into a one-cycle start pulse
// Assumes: strobe level already synchronous to clk_i
// Notes:   one pulse per access, however long the strobe is held
module strobe_edge (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic active_i,
	output logic      pulse_o
);
	typedef struct packed {
		logic prev;
	} edge_state_t;

	edge_state_t state_reg;
	edge_state_t state_next;

	// Remember last level
	always_comb begin
		state_next = state_reg;
		state_next.prev = active_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign pulse_o = active_i & ~state_reg.prev;
endmodule // strobe_edge

// ==== host_data_port.sv ====
// Purpose: slave host data buffer port with status byte and optional handshake pins
// Assumes: host pins synchronous to clk_i; program side gives one-cycle requests
// Notes:   data bus uses three signals, output enable low while driving
//
// Overview of operation
// - 8-bit three-state bus, driven only during a selected host read.
// - Selected host write strobe captures the bus byte into the input buffer.
// - Selected host read places output buffer or status byte on the bus.
// - Address line marks data or command and picks buffer or status on reads.
// - Strobes are ignored unless select, or acknowledge with DMA enabled, is asserted.
// - Program fetch of the input buffer clears input-buffer-full.
// - Program post loads output buffer and sets output-buffer-full.
// - Program copies accumulator bits 4 to 7 into status bits 4 to 7.
// - Upper handshake pins optionally carry output-full, input-full, DMA request, acknowledge.
// - With DMA enabled, a strobe during acknowledge clears DMA request in bound.
// - Reset clears status flags including both buffer-full flags.
module host_data_port (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire host_port_pkg::host_pins_t host_i,
	input  wire logic                     dma_transfer_acknowledge_n_i,
	input  wire host_port_pkg::prog_req_t  prog_i,
	input  wire logic                     hs_flags_en_i,
	input  wire logic                     dma_en_i,
	input  wire logic                     dma_start_i,
	output logic [7:0]                    data_o,
	output logic                          data_oe_n_o,
	output logic [7:0]                    in_byte_o,
	output logic [7:0]                    status_o,
	output logic [3:0]                    hs_pins_o,
	output logic [3:0]                    hs_oe_n_o
);
	typedef struct packed {
		logic [7:0] in_buf;
		logic [7:0] out_buf;
		logic [7:0] status;
		logic [7:0] dout;
		logic       oe_n;
		logic       dma_req;
		logic [3:0] hs;
		logic [3:0] hs_oe_n;
	} port_state_t;

	port_state_t state_reg;
	port_state_t state_next;

	logic dma_sel;
	logic chip_sel;
	logic rd_act;
	logic wr_act;
	logic rd_start;
	logic wr_start;

	// Acknowledge stands in for select, but only for data transfers
	assign dma_sel  = dma_en_i & ~dma_transfer_acknowledge_n_i;
	assign chip_sel = ~host_i.sel_n | dma_sel;
	assign rd_act   = chip_sel & ~host_i.rd_n;
	assign wr_act   = chip_sel & ~host_i.wr_n;

	strobe_edge u_rd_edge (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.active_i (rd_act),
		.pulse_o  (rd_start)
	);

	strobe_edge u_wr_edge (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.active_i (wr_act),
		.pulse_o  (wr_start)
	);

	// Next state: host side, program side, handshake pins
	always_comb begin
		logic status_sel;
		logic dc_eff;
		status_sel = 1'h0;
		dc_eff = 1'h0;
		state_next = state_reg;
		// Under acknowledge the address line is forced to data
		dc_eff = host_i.dc & ~dma_sel;
		status_sel = dc_eff;
		// Host write: capture byte, flag full, note command
		if (wr_start) begin
			state_next.in_buf = host_i.data;
			state_next.status[host_port_pkg::ST_CMD_BIT] = dc_eff;
		end
		// Program fetch clears input full; a same-cycle host write wins
		if (prog_i.fetch) begin
			state_next.status[host_port_pkg::ST_IN_FULL_BIT] = 1'h0;
		end
		if (wr_start) begin
			state_next.status[host_port_pkg::ST_IN_FULL_BIT] = 1'h1;
		end
		// Host read of buffer clears output full; program post wins
		if (rd_start && !status_sel) begin
			state_next.status[host_port_pkg::ST_OUT_FULL_BIT] = 1'h0;
		end
		if (prog_i.post) begin
			state_next.out_buf = prog_i.acc;
			state_next.status[host_port_pkg::ST_OUT_FULL_BIT] = 1'h1;
		end
		if (prog_i.upper_load) begin
			state_next.status[7:host_port_pkg::ST_UPPER_LO] =
				prog_i.acc[7:host_port_pkg::ST_UPPER_LO];
		end
		// Bus driven only while a selected read is held
		state_next.oe_n = ~rd_act;
		if (rd_act) begin
			state_next.dout = status_sel ? state_reg.status : state_reg.out_buf;
		end else begin
			state_next.dout = 8'h00;
		end
		// Request clears on a strobe under acknowledge; a same-cycle start wins
		// so that a fresh request is never lost to the last strobe of a block
		if (!dma_en_i) begin
			state_next.dma_req = 1'h0;
		end else if (dma_start_i) begin
			state_next.dma_req = 1'h1;
		end else if (dma_sel && (rd_start || wr_start)) begin
			state_next.dma_req = 1'h0;
		end
		// Handshake pin group; acknowledge pin stays an input
		state_next.hs[host_port_pkg::HS_OUT_FULL] = hs_flags_en_i &
			state_next.status[host_port_pkg::ST_OUT_FULL_BIT];
		state_next.hs[host_port_pkg::HS_IN_FULL] = hs_flags_en_i &
			state_next.status[host_port_pkg::ST_IN_FULL_BIT];
		state_next.hs[host_port_pkg::HS_DMA_REQ] = state_next.dma_req;
		state_next.hs[host_port_pkg::HS_DMA_ACK] = 1'h0;
		state_next.hs_oe_n = {1'h1, ~dma_en_i, ~hs_flags_en_i, ~hs_flags_en_i};
	end

	// Register; reset clears every status flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= '0;
			state_reg.status <= host_port_pkg::ST_RESET;
			state_reg.oe_n <= 1'h1;
			state_reg.hs_oe_n <= 4'hF;
		end else begin
			state_reg <= state_next;
		end
	end

	assign data_o      = state_reg.dout;
	assign data_oe_n_o = state_reg.oe_n;
	assign in_byte_o   = state_reg.in_buf;
	assign status_o    = state_reg.status;
	assign hs_pins_o   = state_reg.hs;
	assign hs_oe_n_o   = state_reg.hs_oe_n;

	// Helper: cycles the request has stood since a strobe under acknowledge
	logic [3:0] req_age_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i || !state_reg.dma_req || dma_start_i) begin
			req_age_reg <= 4'h0;
		end else if (dma_sel && (rd_start || wr_start)) begin
			req_age_reg <= 4'h1;
		end else if (req_age_reg != 4'h0 && req_age_reg != 4'hF) begin
			req_age_reg <= req_age_reg + 4'h1;
		end
	end

	a_req_clear_next: assert property (@(posedge clk_i) disable iff (rst_i)
		dma_sel && (rd_start || wr_start) && !dma_start_i |=> !state_reg.dma_req)
		else $error("DMA request not cleared after strobe");
	a_req_clear_bound: assert property (@(posedge clk_i) disable iff (rst_i)
		req_age_reg < 4'(host_port_pkg::DMA_REQ_CLEAR_CYC))
		else $error("DMA request stood past its bound");
	a_bus_float: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rd_act) |-> data_oe_n_o)
		else $error("Bus driven without selected read");
	a_write_capture: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_start |=> in_byte_o == $past(host_i.data) &&
		status_o[host_port_pkg::ST_IN_FULL_BIT])
		else $error("Host write not captured");
	a_read_status: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_act && host_i.dc && !dma_sel |=> data_o == $past(status_o))
		else $error("Status byte not on bus");
	a_select_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		host_i.sel_n && !dma_sel |=> data_oe_n_o)
		else $error("Unselected strobe acted");
	a_fetch_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		prog_i.fetch && !wr_start |=> !status_o[host_port_pkg::ST_IN_FULL_BIT])
		else $error("Fetch did not clear input full");
	a_post_set: assert property (@(posedge clk_i) disable iff (rst_i)
		prog_i.post |=> status_o[host_port_pkg::ST_OUT_FULL_BIT])
		else $error("Post did not set output full");
	a_upper_load: assert property (@(posedge clk_i) disable iff (rst_i)
		prog_i.upper_load |=> status_o[7:4] == $past(prog_i.acc[7:4]))
		else $error("Upper status not loaded");
	a_reset_clear: assert property (@(posedge clk_i)
		rst_i |=> status_o == host_port_pkg::ST_RESET)
		else $error("Reset left status set");
	c_host_write: cover property (@(posedge clk_i) wr_start && !dma_sel);
	c_dma_read: cover property (@(posedge clk_i) rd_start && dma_sel);
	c_post_then_read: cover property (@(posedge clk_i) prog_i.post ##[1:20] rd_start);
endmodule // host_data_port

// ==== host_master_model.sv ====
// Purpose: master-side model of the shared host data bus
// Assumes: device output enable is low while the device drives
// Notes:   an undriven bus flips every cycle so a stale byte never reads as good
module host_master_model (
	input  wire logic       clk_i,
	input  wire logic       drv_en_i,
	input  wire logic [7:0] drv_val_i,
	input  wire logic [7:0] dev_data_i,
	input  wire logic       dev_oe_n_i,
	output logic [7:0]      bus_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] last_reg;
	// Resolve the wire from both drivers; the master writes only with a strobe
	always_comb begin
		if (!dev_oe_n_i) bus_o = dev_data_i;
		else if (drv_en_i) bus_o = drv_val_i;
		else bus_o = ~last_reg;
	end
	// Remember the last level so a floating bus shows its inverse
	always_ff @(posedge clk_i) begin
		last_reg <= bus_o;
	end
endmodule // host_master_model

// ==== host_data_port_tb.sv ====
// Purpose: self-checking bench for the host data port
// Assumes: strobes held four edges, then a high gap of two edges
// Notes:   the master model resolves the bus wire
module host_data_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
		$display("[FAIL] %0t mismatch %h vs %h", $time, (a), (b)); end end
	logic clk_i = 0, rst_i = 1, dma_transfer_acknowledge_n_i = 1, hs_en = 0, dma_en = 0, dma_st = 0;
	logic sel_n = 1, rd_n = 1, wr_n = 1, dc = 0, drv_en = 0;
	logic [7:0] drv_val = 8'h00, bus, rbyte, data_o, in_byte_o, status_o;
	logic       data_oe_n_o;
	logic [3:0] hs_pins_o, hs_oe_n_o;
	host_port_pkg::host_pins_t hp;
	host_port_pkg::prog_req_t  prog = '0;
	int n_fail = 0, num_checks = 0;
	assign hp = '{sel_n, rd_n, wr_n, dc, bus};
	always #12.5 clk_i = ~clk_i;
	host_data_port host_data_port_inst (.clk_i(clk_i), .rst_i(rst_i), .host_i(hp),
		.dma_transfer_acknowledge_n_i(dma_transfer_acknowledge_n_i), .prog_i(prog), .hs_flags_en_i(hs_en), .dma_en_i(dma_en),
		.dma_start_i(dma_st), .data_o(data_o), .data_oe_n_o(data_oe_n_o),
		.in_byte_o(in_byte_o), .status_o(status_o), .hs_pins_o(hs_pins_o),
		.hs_oe_n_o(hs_oe_n_o));
	host_master_model host_master_model_inst (.clk_i(clk_i), .drv_en_i(drv_en),
		.drv_val_i(drv_val), .dev_data_i(data_o), .dev_oe_n_i(data_oe_n_o), .bus_o(bus));
	task end_of_test;
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// One host access; the bus is sampled just before the strobe is released
	task acc(input logic s, input logic r, input logic d, input logic [7:0] v);
		@(posedge clk_i);
		sel_n <= ~s;
		dc <= d;
		drv_val <= v;
		drv_en <= ~r;
		if (r) rd_n <= 0;
		else wr_n <= 0;
		repeat (3) @(posedge clk_i);
		#1 rbyte = bus;
		@(posedge clk_i);
		{sel_n, rd_n, wr_n, drv_en} <= 4'hE;
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	// One-cycle program-side request
	task pg(input host_port_pkg::prog_req_t p);
		@(posedge clk_i);
		prog <= p;
		@(posedge clk_i);
		prog <= '0;
		@(posedge clk_i);
		#1;
	endtask
	// Watchdog: the tests need about 2 us
	initial begin
		#20us;
		n_fail++;
		end_of_test();
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		#1 `CHK(status_o, host_port_pkg::ST_RESET)
		`CHK({data_oe_n_o, hs_oe_n_o}, 5'h1F)
		acc(1, 0, 0, 8'h3C);
		`CHK({in_byte_o, status_o}, 16'h3C02)
		acc(1, 0, 1, 8'hC3);
		`CHK(status_o, 8'h0A)
		acc(0, 0, 0, 8'h55);
		`CHK(in_byte_o, 8'hC3)
		pg('{1'b1, 1'b0, 1'b0, 8'h00});
		`CHK(status_o, 8'h08)
		$display("test host write done");
		@(posedge clk_i) hs_en <= 1;
		pg('{1'b0, 1'b1, 1'b0, 8'h5A});
		`CHK({status_o, hs_pins_o[0]}, 9'h013)
		acc(1, 1, 1, 8'h00);
		`CHK(rbyte, 8'h09)
		acc(1, 1, 0, 8'h00);
		`CHK({rbyte, status_o, data_oe_n_o}, 17'h0B411)
		pg('{1'b0, 1'b0, 1'b1, 8'hA5});
		`CHK(status_o, 8'hA8)
		$display("test host read done");
		@(posedge clk_i) dma_en <= 1;
		dma_st <= 1;
		@(posedge clk_i) dma_st <= 0;
		dma_transfer_acknowledge_n_i <= 0;
		@(posedge clk_i);
		#1 `CHK(hs_pins_o[host_port_pkg::HS_DMA_REQ], 1'h1)
		`CHK(hs_oe_n_o, 4'h8)
		acc(0, 0, 1, 8'h77);
		`CHK({in_byte_o, status_o, hs_pins_o[2:1]}, 18'h1DE89)
		@(posedge clk_i) dma_transfer_acknowledge_n_i <= 1;
		pg('{1'b0, 1'b1, 1'b0, 8'h11});
		@(posedge clk_i) rst_i <= 1;
		@(posedge clk_i) rst_i <= 0;
		@(posedge clk_i);
		#1 `CHK(status_o, 8'h00)
		$display("test dma and reset done");
		end_of_test();
	end
endmodule // host_data_port_tb
